// ---- pkg/lpcb_pkg.sv ----
// Shared constants and types of the low-power calendar and backup block.
// Assumes a single 20 MHz clock that keeps running in Stop and Standby.
package lpcb_pkg;
   localparam int CLK_NS        = 50;
   localparam int CLK_HZ        = 20_000_000;
   localparam int SUB_W         = 10;
   localparam int SUB_STEPS     = 1 << SUB_W;
   localparam int PRESC_DEF     = CLK_HZ / SUB_STEPS;
   localparam int CAL_OUT_HZ    = 512;
   localparam int MAINS_50      = 50;
   localparam int MAINS_60      = 60;
   localparam int WAKE_UNIT_NS  = 120_000;
   localparam int WAKE_UNIT_CYC = (WAKE_UNIT_NS + CLK_NS - 1) / CLK_NS;
   localparam int WAKE_W        = 30;
   localparam int STBY_EXIT_NS  = 60_000;
   localparam int STBY_EXIT_CYC = STBY_EXIT_NS / CLK_NS;
   localparam int STOP_EXIT_NS  = 8_000;
   localparam int STOP_EXIT_CYC = STOP_EXIT_NS / CLK_NS;
   localparam int EXIT_W        = 11;
   localparam int FILT_DEF      = 4;
   localparam int N_TAMP        = 3;
   localparam int N_ALARM       = 2;
   localparam int BK_WORDS      = 32;
   localparam int BK_AW         = 5;
   localparam int FLG_ALR0      = 0;
   localparam int FLG_WAKE      = 2;
   localparam int FLG_TS        = 3;
   localparam int FLG_TAMP0     = 4;
   localparam int N_FLAGS       = 7;
   localparam logic [7:0] RST_DATE = 8'h01;
   localparam logic [7:0] RST_MON  = 8'h01;
   localparam logic [7:0] RST_YEAR = 8'h00;
   localparam logic [7:0] RST_HOUR = 8'h00;
   localparam logic [2:0] RST_WDAY = 3'h1;
   typedef enum logic [1:0] {PWR_RUN, PWR_STOP, PWR_STANDBY} lpcb_pwr_t;
   typedef enum logic {EX_IDLE, EX_WAIT} lpcb_exit_t;
endpackage : lpcb_pkg

// ---- hw/lpcb_rtc.sv ----
// Calendar timer with alarms, wakeup timer, timestamp, tamper and backup words.
// Assumes all inputs synchronous to clk; the power controller reads the wake request.
`timescale 1ns/10ps
// What this block does
// - Binary sub-second count and BCD calendar registers second to year, hour in 12 or 24 format.
// - Date rolls over at month end for 28, 29, 30 and 31 days.
// - Two independent programmable alarms, each interrupting and waking the device.
// - Periodic wakeup timer from 120 us to 36 hours, interrupting and waking.
// - A 512 Hz calibration output can be driven on a pin.
// - Digital compensation adds or removes timebase pulses against crystal drift.
// - Optional second correction against a 50 or 60 Hz mains reference.
// - Running calendar can be shifted by sub-seconds without stopping the count.
// - External timestamp event captures the calendar and raises an interrupt.
// - Thirty-two 32-bit backup words, 128 bytes of storage.
// - A tamper event clears every backup word.
// - A change on any of three tamper pins clears backups and interrupts.
// - Each tamper input has an optional digital glitch filter.
// - Alarms, tamper, timestamp and wakeup events request exit from Standby within 60 us.
// - Stop and Standby do not halt the calendar or its clock source.
// - Calendar and wakeup state survive Standby; only reset clears the calendar, and reset or wakeEnable low reloads the wakeup timer.
// - Chosen low-speed oscillator stays on in Standby while the calendar runs.
// - Calendar events wake from Stop within 8 us.
module lpcb_rtc
   import lpcb_pkg::*;
#(
   parameter int PRESC    = PRESC_DEF,
   parameter int FILT_LEN = FILT_DEF
) (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic                      calEnable,
   input  wire logic                      oscSelInternal,
   input  wire logic                      hourFmt12,
   input  wire logic                      calOutEn,
   input  wire logic signed [7:0]         calAdjust,
   input  wire logic                      setStrobe,
   input  wire logic [7:0]                setSec,
   input  wire logic [7:0]                setMin,
   input  wire logic [7:0]                setHour,
   input  wire logic                      setPm,
   input  wire logic [2:0]                setWday,
   input  wire logic [7:0]                setDate,
   input  wire logic [7:0]                setMon,
   input  wire logic [7:0]                setYear,
   input  wire logic                      shiftStrobe,
   input  wire logic                      shiftAddSec,
   input  wire logic [SUB_W-1:0]          shiftFrac,
   input  wire logic                      refEnable,
   input  wire logic                      ref60Hz,
   input  wire logic                      refIn,
   input  wire logic [N_ALARM-1:0]        alarmEnable,
   input  wire logic [N_ALARM-1:0][3:0]   alarmMask,
   input  wire logic [N_ALARM-1:0][7:0]   alarmSec,
   input  wire logic [N_ALARM-1:0][7:0]   alarmMin,
   input  wire logic [N_ALARM-1:0][7:0]   alarmHour,
   input  wire logic [N_ALARM-1:0]        alarmPm,
   input  wire logic [N_ALARM-1:0][7:0]   alarmDate,
   input  wire logic                      wakeEnable,
   input  wire logic [WAKE_W-1:0]         wakeReload,
   input  wire logic                      tsEnable,
   input  wire logic                      tsIn,
   input  wire logic [N_TAMP-1:0]         tampIn,
   input  wire logic [N_TAMP-1:0]         tampFiltEn,
   input  wire logic                      bkWrEn,
   input  wire logic [BK_AW-1:0]          bkAddr,
   input  wire logic [31:0]               bkWrData,
   input  wire logic [N_FLAGS-1:0]        flagClear,
   input  wire logic [N_FLAGS-1:0]        irqEnable,
   input  wire lpcb_pwr_t                 pwrState,
   output logic [SUB_W-1:0]               subSec_q,
   output logic [7:0]                     sec_q,
   output logic [7:0]                     min_q,
   output logic [7:0]                     hour_q,
   output logic                           pm_q,
   output logic                           fmt12_q,
   output logic [2:0]                     wday_q,
   output logic [7:0]                     date_q,
   output logic [7:0]                     mon_q,
   output logic [7:0]                     year_q,
   output logic [SUB_W-1:0]               tsSub_q,
   output logic [7:0]                     tsSec_q,
   output logic [7:0]                     tsMin_q,
   output logic [7:0]                     tsHour_q,
   output logic                           tsPm_q,
   output logic [7:0]                     tsDate_q,
   output logic [7:0]                     tsMon_q,
   output logic                           tsOverflow_q,
   output logic [N_FLAGS-1:0]             flags_q,
   output logic                           irq_q,
   output logic                           wakeReq_q,
   output logic                           exitLate_q,
   output logic                           calOut_q,
   output logic                           xtalOn_q,
   output logic                           intOscOn_q,
   output logic [31:0]                    bkRdData_q
);
   if (PRESC < 256 || PRESC > 65000 || FILT_LEN < 1 || FILT_LEN > 255 || SUB_STEPS != 2 * CAL_OUT_HZ)
      $error("lpcb_rtc: unsupported PRESC, FILT_LEN or sub-second rate");

   function automatic logic [7:0] bcdInc(input logic [7:0] v);
      bcdInc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
   endfunction : bcdInc

   function automatic logic [7:0] lastDay(input logic [7:0] m, input logic [7:0] y);
      logic leap;
      leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                  : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
      case (m)
         8'h02:                      lastDay = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: lastDay = 8'h30;
         default:                    lastDay = 8'h31;
      endcase
   endfunction : lastDay

   // Timebase: one sub-second step per prescaler wrap
   logic [15:0]       presc_q;
   logic [15:0]       prescTop;
   logic              subTick;
   always_comb begin
      prescTop = 16'(PRESC - 1);
      // Correction applied once per second, on the last sub-second step, so one 512 Hz half-period per second is longer or shorter
      if (&subSec_q) prescTop = prescTop + 16'(calAdjust);
   end
   assign subTick = calEnable && (presc_q >= prescTop);

   // Calendar keeps counting whatever pwrState says
   always_ff @(posedge clk) begin
      if (!rst_n || !calEnable) presc_q <= '0;
      else if (subTick) presc_q <= '0;
      else presc_q <= presc_q + 16'h0001;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) calOut_q <= 1'b0;
      else if (!calOutEn) calOut_q <= 1'b0;
      else if (subTick) calOut_q <= !calOut_q;
   end

   // Mains reference
   logic       refPrev_q;
   logic [5:0] refCnt_q;
   logic       refSecond;
   assign refSecond = refEnable && refIn && !refPrev_q
                      && refCnt_q == (ref60Hz ? 6'(MAINS_60 - 1) : 6'(MAINS_50 - 1));
   always_ff @(posedge clk) begin
      if (!rst_n || !refEnable) begin
         refPrev_q <= 1'b0;
         refCnt_q  <= '0;
      end else begin
         refPrev_q <= refIn;
         if (refSecond) refCnt_q <= '0;
         else if (refIn && !refPrev_q) refCnt_q <= refCnt_q + 6'h01;
      end
   end

   // Sub-second shift and second advance
   logic [SUB_W+1:0] shiftSum;
   logic             shiftOk;
   logic             secAdv;
   assign shiftSum = {2'b00, subSec_q} + (shiftAddSec ? (SUB_W+2)'(SUB_STEPS) : '0) - {2'b00, shiftFrac};
   // A pure subtract past zero would need a borrow from seconds; it is ignored
   assign shiftOk  = shiftStrobe && (shiftAddSec || shiftFrac <= subSec_q);
   always_comb begin
      if (setStrobe) secAdv = 1'b0;
      else if (shiftOk) secAdv = shiftSum[SUB_W];
      else if (refSecond) secAdv = subSec_q[SUB_W-1];
      else secAdv = subTick && (&subSec_q);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) subSec_q <= '0;
      else if (setStrobe) subSec_q <= '0;
      else if (shiftOk) subSec_q <= shiftSum[SUB_W-1:0];
      else if (refSecond) subSec_q <= '0;
      else if (subTick) subSec_q <= subSec_q + 1'b1;
   end

   // Calendar next value
   logic [7:0] secD, minD, hourD, dateD, monD, yearD;
   logic [2:0] wdayD;
   logic       pmD, dayCarry;
   always_comb begin
      secD = sec_q;
      minD = min_q;
      hourD = hour_q;
      pmD = pm_q;
      wdayD = wday_q;
      dateD = date_q;
      monD = mon_q;
      yearD = year_q;
      dayCarry = 1'b0;
      if (secAdv) begin
         secD = bcdInc(sec_q);
         if (sec_q == 8'h59) begin
            secD = 8'h00;
            minD = bcdInc(min_q);
            if (min_q == 8'h59) begin
               minD = 8'h00;
               if (fmt12_q) begin
                  hourD = (hour_q == 8'h12) ? 8'h01 : bcdInc(hour_q);
                  if (hour_q == 8'h11) begin
                     pmD = !pm_q;
                     dayCarry = pm_q;
                  end
               end else begin
                  hourD = (hour_q == 8'h23) ? 8'h00 : bcdInc(hour_q);
                  dayCarry = (hour_q == 8'h23);
               end
            end
         end
      end
      if (dayCarry) begin
         wdayD = (wday_q == 3'h7) ? 3'h1 : wday_q + 3'h1;
         dateD = bcdInc(date_q);
         if (date_q == lastDay(mon_q, year_q)) begin
            dateD = 8'h01;
            monD = bcdInc(mon_q);
            if (mon_q == 8'h12) begin
               monD = 8'h01;
               yearD = (year_q == 8'h99) ? 8'h00 : bcdInc(year_q);
            end
         end
      end
   end

   // Only rst_n clears the calendar; it lives in the retained domain
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sec_q <= 8'h00;
         min_q <= 8'h00;
         hour_q <= RST_HOUR;
         pm_q <= 1'b0;
         fmt12_q <= 1'b0;
         wday_q <= RST_WDAY;
         date_q <= RST_DATE;
         mon_q <= RST_MON;
         year_q <= RST_YEAR;
      end else if (setStrobe) begin
         sec_q <= setSec;
         min_q <= setMin;
         hour_q <= setHour;
         pm_q <= hourFmt12 && setPm;
         fmt12_q <= hourFmt12;
         wday_q <= setWday;
         date_q <= setDate;
         mon_q <= setMon;
         year_q <= setYear;
      end else begin
         sec_q <= secD;
         min_q <= minD;
         hour_q <= hourD;
         pm_q <= pmD;
         wday_q <= wdayD;
         date_q <= dateD;
         mon_q <= monD;
         year_q <= yearD;
      end
   end

   // Alarms compare the calendar one cycle after each second step
   logic               secPulse_q;
   logic [N_ALARM-1:0] alarmHit;
   always_ff @(posedge clk) begin
      if (!rst_n) secPulse_q <= 1'b0;
      else secPulse_q <= secAdv;
   end
   for (genvar a = 0; a < N_ALARM; a++) begin : g_alarm
      assign alarmHit[a] = secPulse_q && alarmEnable[a]
                           && (alarmMask[a][0] || alarmSec[a] == sec_q)
                           && (alarmMask[a][1] || alarmMin[a] == min_q)
                           && (alarmMask[a][2] || (alarmHour[a] == hour_q && (!fmt12_q || alarmPm[a] == pm_q)))
                           && (alarmMask[a][3] || alarmDate[a] == date_q);
   end

   // Wakeup timer: interval is (wakeReload + 1) units of 120 us
   logic [11:0]       wkPre_q;
   logic [WAKE_W-1:0] wkCnt_q;
   logic              wkUnit, wkEvt;
   assign wkUnit = wakeEnable && wkPre_q == 12'(WAKE_UNIT_CYC - 1);
   assign wkEvt  = wkUnit && wkCnt_q == '0;
   always_ff @(posedge clk) begin
      if (!rst_n || !wakeEnable) begin
         wkPre_q <= '0;
         wkCnt_q <= wakeReload;
      end else begin
         wkPre_q <= wkUnit ? 12'h000 : wkPre_q + 12'h001;
         if (wkEvt) wkCnt_q <= wakeReload;
         else if (wkUnit) wkCnt_q <= wkCnt_q - 1'b1;
      end
   end

   // Timestamp on a rising edge of tsIn
   logic tsPrev_q, tsEvt;
   assign tsEvt = tsEnable && tsIn && !tsPrev_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tsPrev_q <= 1'b0;
         tsSub_q <= '0;
         {tsSec_q, tsMin_q, tsHour_q, tsDate_q, tsMon_q} <= '0;
         tsPm_q <= 1'b0;
         tsOverflow_q <= 1'b0;
      end else begin
         tsPrev_q <= tsIn;
         if (tsEvt) begin
            tsSub_q <= subSec_q;
            tsSec_q <= sec_q;
            tsMin_q <= min_q;
            tsHour_q <= hour_q;
            tsPm_q <= pm_q;
            tsDate_q <= date_q;
            tsMon_q <= mon_q;
         end
         // A second stamp while the flag is still up is reported, set wins
         if (tsEvt && flags_q[FLG_TS]) tsOverflow_q <= 1'b1;
         else if (flagClear[FLG_TS]) tsOverflow_q <= 1'b0;
      end
   end

   // Tamper filter; the first cycle after reset loads the pin level silently
   logic                      armed_q;
   logic [N_TAMP-1:0]         tStable_q, tEvt;
   logic [N_TAMP-1:0][7:0]    tCnt_q;
   always_ff @(posedge clk) begin
      if (!rst_n) armed_q <= 1'b0;
      else armed_q <= 1'b1;
   end
   for (genvar t = 0; t < N_TAMP; t++) begin : g_tamp
      logic accept;
      assign accept  = !tampFiltEn[t] || tCnt_q[t] == 8'(FILT_LEN - 1);
      assign tEvt[t] = armed_q && tampIn[t] != tStable_q[t] && accept;
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            tStable_q[t] <= 1'b0;
            tCnt_q[t] <= '0;
         end else if (!armed_q) begin
            tStable_q[t] <= tampIn[t];
         end else if (tampIn[t] == tStable_q[t] || accept) begin
            tStable_q[t] <= tampIn[t];
            tCnt_q[t] <= '0;
         end else begin
            tCnt_q[t] <= tCnt_q[t] + 8'h01;
         end
      end
   end

   // Backup words
   logic [31:0] bkMem [BK_WORDS];
   logic        tampAny;
   assign tampAny = |tEvt;
   always_ff @(posedge clk) begin
      if (!rst_n || tampAny) begin
         for (int i = 0; i < BK_WORDS; i++) bkMem[i] <= '0;
      end else if (bkWrEn) begin
         bkMem[bkAddr] <= bkWrData;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n || tampAny) bkRdData_q <= '0;
      else bkRdData_q <= bkMem[bkAddr];
   end

   // Sticky flags; a new event beats a clear in the same cycle
   logic [N_FLAGS-1:0] flagSet;
   assign flagSet = {tEvt, tsEvt, wkEvt, alarmHit};
   always_ff @(posedge clk) begin
      if (!rst_n) flags_q <= '0;
      else flags_q <= (flags_q & ~flagClear) | flagSet;
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_q <= 1'b0;
         wakeReq_q <= 1'b0;
      end else begin
         irq_q <= |(flags_q & irqEnable);
         wakeReq_q <= |(flags_q & irqEnable) && pwrState != PWR_RUN;
      end
   end

   // Exit watch: flags a power controller that leaves the request unanswered too long
   lpcb_exit_t        exState_q;
   logic [EXIT_W-1:0] exCnt_q;
   logic [EXIT_W-1:0] exLimit;
   assign exLimit = (pwrState == PWR_STANDBY) ? EXIT_W'(STBY_EXIT_CYC) : EXIT_W'(STOP_EXIT_CYC);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         exState_q <= EX_IDLE;
         exCnt_q <= '0;
         exitLate_q <= 1'b0;
      end else begin
         case (exState_q)
            EX_IDLE: begin
               exCnt_q <= '0;
               if (wakeReq_q) begin
                  exState_q <= EX_WAIT;
                  exitLate_q <= 1'b0;
               end
            end
            EX_WAIT: begin
               exCnt_q <= exCnt_q + 1'b1;
               if (pwrState == PWR_RUN || !wakeReq_q) exState_q <= EX_IDLE;
               else if (exCnt_q >= exLimit) exitLate_q <= 1'b1;
            end
            default: exState_q <= EX_IDLE;
         endcase
      end
   end

   // Selected oscillator enable held in every power state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         xtalOn_q <= 1'b0;
         intOscOn_q <= 1'b0;
      end else begin
         xtalOn_q <= calEnable && !oscSelInternal;
         intOscOn_q <= calEnable && oscSelInternal;
      end
   end
endmodule : lpcb_rtc

// ---- sim/lpcb_pwr_model.sv ----
// Power controller model: enters Standby on request, leaves it after a delay.
// Assumes the wake request of the calendar block and one shared clock.
`timescale 1ns/10ps
module lpcb_pwr_model
   import lpcb_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        sleepReq,
   input  wire logic        wakeReq,
   input  wire logic [15:0] exitDelay,
   output lpcb_pwr_t        pwrState
);
   logic [15:0] cnt_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pwrState <= PWR_RUN;
         cnt_q <= '0;
      end else if (sleepReq) begin
         pwrState <= PWR_STANDBY;
      end else if (pwrState != PWR_RUN && (wakeReq || cnt_q != '0)) begin
         // Once started, the exit completes even if the request drops
         if (cnt_q >= exitDelay) begin
            pwrState <= PWR_RUN;
            cnt_q <= '0;
         end else begin
            cnt_q <= cnt_q + 16'h1;
         end
      end
   end
endmodule : lpcb_pwr_model

// ---- sim/lpcb_rtc_properties.sv ----
// Port checker of the calendar block.
// Assumes it is bound to lpcb_rtc and sees only its ports.
`timescale 1ns/10ps
module lpcb_rtc_checker
   import lpcb_pkg::*;
(
   input wire logic               clk,
   input wire logic               rst_n,
   input wire logic               setStrobe,
   input wire logic [7:0]         setSec,
   input wire logic               tsEnable,
   input wire logic               tsIn,
   input wire logic [N_FLAGS-1:0] flagClear,
   input wire logic [N_FLAGS-1:0] irqEnable,
   input wire lpcb_pwr_t          pwrState,
   input wire logic [SUB_W-1:0]   subSec_q,
   input wire logic [7:0]         sec_q,
   input wire logic [7:0]         min_q,
   input wire logic [7:0]         hour_q,
   input wire logic               fmt12_q,
   input wire logic [7:0]         tsSec_q,
   input wire logic [N_FLAGS-1:0] flags_q,
   input wire logic               irq_q,
   input wire logic               wakeReq_q,
   input wire logic [31:0]        bkRdData_q
);
   logic anyEn;
   logic tampAny;
   assign anyEn = |(flags_q & irqEnable);
   assign tampAny = |flags_q[6:4];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence setCmd; setStrobe; endsequence
   sequence tsRise; tsEnable && tsIn && !$past(tsIn); endsequence
   irq_follow_a: assert property (irq_q == $past(anyEn))
      else $error("irq does not follow enabled flags");
   flag_sticky_a: assert property ((($past(flags_q) & ~$past(flagClear)) & ~flags_q) == '0)
      else $error("flag dropped without clear");
   wake_irq_a: assert property (wakeReq_q |-> irq_q)
      else $error("wake request without pending event");
   standby_wake_a: assert property (irq_q && $past(pwrState, 1) == PWR_STANDBY && $past(pwrState, 2) == PWR_STANDBY
      |-> wakeReq_q)
      else $error("no wake request in standby");
   tamper_clear_a: assert property ($rose(tampAny) |-> bkRdData_q == 32'h0)
      else $error("backup not cleared on tamper");
   set_load_a: assert property (setCmd |=> sec_q == $past(setSec) && subSec_q == '0)
      else $error("calendar set not loaded");
   bcd_range_a: assert property (sec_q[3:0] <= 4'h9 && sec_q <= 8'h59 && min_q[3:0] <= 4'h9 && min_q <= 8'h59)
      else $error("second or minute out of range");
   hour_range_a: assert property (fmt12_q ? (hour_q >= 8'h01 && hour_q <= 8'h12) : hour_q <= 8'h23)
      else $error("hour out of range");
   ts_capture_a: assert property (tsRise |=> flags_q[FLG_TS] && tsSec_q == $past(sec_q))
      else $error("timestamp not captured");
endmodule : lpcb_rtc_checker
bind lpcb_rtc lpcb_rtc_checker u_chk (.clk, .rst_n, .setStrobe, .setSec, .tsEnable, .tsIn, .flagClear, .irqEnable,
   .pwrState, .subSec_q, .sec_q, .min_q, .hour_q, .fmt12_q, .tsSec_q, .flags_q, .irq_q, .wakeReq_q, .bkRdData_q);

// ---- sim/lpcb_rtc_bench.sv ----
// Self-checking bench of the calendar block with a power controller model.
// Assumes a 256-cycle prescaler; seconds are stepped by the shift input, never by waiting.
`timescale 1ns/10ps
module lpcb_rtc_bench;
   import lpcb_pkg::*;
   localparam int FL = 4, PR = 256;
   localparam logic [23:0] ROLL_IN [6] = '{24'h010228, 24'h040228, 24'h040229, 24'h040430, 24'h991231, 24'h040131};
   localparam logic [23:0] ROLL_OUT [6] = '{24'h010301, 24'h040229, 24'h040301, 24'h040501, 24'h000101, 24'h040201};
   logic clk = 0, rst_n = 0, calEnable = 1, oscSelInternal = 0, hourFmt12 = 0, calOutEn = 1, setStrobe = 0;
   logic setPm = 0, shiftStrobe = 0, shiftAddSec = 0, refEnable = 0, ref60Hz = 0, refIn = 0;
   logic wakeEnable = 0, tsEnable = 0, tsIn = 0, bkWrEn = 0, sleepReq = 0;
   logic signed [7:0] calAdjust = 0;
   logic [7:0] setSec = 0, setMin = 0, setHour = 0, setDate = 8'h01, setMon = 8'h01, setYear = 0;
   logic [2:0] setWday = 3'h7;
   logic [SUB_W-1:0] shiftFrac = 0;
   logic [N_ALARM-1:0] alarmEnable = 0, alarmPm = 0;
   logic [N_ALARM-1:0][3:0] alarmMask = '1;
   logic [N_ALARM-1:0][7:0] alarmSec = 0, alarmMin = 0, alarmHour = 0, alarmDate = 0;
   logic [WAKE_W-1:0] wakeReload = 0;
   logic [N_TAMP-1:0] tampIn = 0, tampFiltEn = 0;
   logic [BK_AW-1:0] bkAddr = 0;
   logic [31:0] bkWrData = 0, bkRdData_q;
   logic [N_FLAGS-1:0] flagClear = 0, irqEnable = 0, flags_q;
   logic [15:0] exitDelay = 16'h000A;
   lpcb_pwr_t pwrState;
   logic [SUB_W-1:0] subSec_q, tsSub_q;
   logic [7:0] sec_q, min_q, hour_q, date_q, mon_q, year_q, tsSec_q, tsMin_q, tsHour_q, tsDate_q, tsMon_q;
   logic pm_q, fmt12_q, tsPm_q, tsOverflow_q, irq_q, wakeReq_q, exitLate_q, calOut_q, xtalOn_q, intOscOn_q;
   logic [2:0] wday_q;
   int n_errors = 0, compares = 0;
   lpcb_rtc #(.PRESC(PR), .FILT_LEN(FL)) DUT (.clk, .rst_n, .calEnable, .oscSelInternal, .hourFmt12, .calOutEn,
      .calAdjust, .setStrobe, .setSec, .setMin, .setHour, .setPm, .setWday, .setDate, .setMon, .setYear, .shiftStrobe,
      .shiftAddSec, .shiftFrac, .refEnable, .ref60Hz, .refIn, .alarmEnable, .alarmMask, .alarmSec, .alarmMin,
      .alarmHour, .alarmPm, .alarmDate, .wakeEnable, .wakeReload, .tsEnable, .tsIn, .tampIn, .tampFiltEn, .bkWrEn,
      .bkAddr, .bkWrData, .flagClear, .irqEnable, .pwrState, .subSec_q, .sec_q, .min_q, .hour_q, .pm_q, .fmt12_q,
      .wday_q, .date_q, .mon_q, .year_q, .tsSub_q, .tsSec_q, .tsMin_q, .tsHour_q, .tsPm_q, .tsDate_q, .tsMon_q,
      .tsOverflow_q, .flags_q, .irq_q, .wakeReq_q, .exitLate_q, .calOut_q, .xtalOn_q, .intOscOn_q, .bkRdData_q);
   lpcb_pwr_model PWR (.clk, .rst_n, .sleepReq, .wakeReq(wakeReq_q), .exitDelay, .pwrState);
   always #25 clk = ~clk;
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #5;
   endtask : tick
   task automatic pulse_clear;
      flagClear = '1;
      tick(1);
      flagClear = '0;
   endtask : pulse_clear
   task automatic set_time(input logic [7:0] h, m, s, input logic [23:0] ymd, input logic f12, p);
      {setHour, setMin, setSec, setYear, setMon, setDate, hourFmt12, setPm} = {h, m, s, ymd, f12, p};
      setStrobe = 1;
      tick(1);
      setStrobe = 0;
   endtask : set_time
   task automatic shift_sec(input logic add, input logic [SUB_W-1:0] frac);
      {shiftAddSec, shiftFrac} = {add, frac};
      shiftStrobe = 1;
      tick(1);
      shiftStrobe = 0;
      tick(2);
   endtask : shift_sec
   task automatic bk_write(input logic [BK_AW-1:0] a, input logic [31:0] d);
      {bkAddr, bkWrData} = {a, d};
      bkWrEn = 1;
      tick(1);
      bkWrEn = 0;
   endtask : bk_write
   task automatic t_roll;
      for (int i = 0; i < 6; i++) begin
         set_time(8'h23, 8'h59, 8'h59, ROLL_IN[i], 0, 0);
         shift_sec(1, '0);
         chk({year_q, mon_q, date_q}, ROLL_OUT[i]);
         chk({wday_q, hour_q, min_q, sec_q}, 27'h1000000);
      end
      set_time(8'h11, 8'h59, 8'h59, 24'h010101, 1, 0);
      shift_sec(1, '0);
      chk({pm_q, hour_q}, 9'h112);
      set_time(8'h12, 8'h59, 8'h59, 24'h010101, 1, 1);
      shift_sec(1, '0);
      chk({pm_q, hour_q}, 9'h101);
      set_time(8'h11, 8'h59, 8'h59, 24'h010101, 1, 1);
      shift_sec(1, '0);
      chk({pm_q, hour_q, date_q}, 17'h01202);
      set_time(8'h00, 8'h00, 8'h30, 24'h010101, 0, 0);
      shift_sec(0, 10'h005);
      chk(sec_q, 8'h30);
   endtask : t_roll
   task automatic t_ts;
      set_time(8'h10, 8'h20, 8'h30, 24'h050607, 0, 0);
      tsEnable = 1;
      tsIn = 1;
      tick(2);
      chk({flags_q[FLG_TS], tsOverflow_q, tsMon_q, tsDate_q, tsHour_q, tsMin_q, tsSec_q}, 42'h20607102030);
      tsIn = 0;
      tick(1);
      tsIn = 1;
      tick(2);
      chk(tsOverflow_q, 1'b1);
      {tsIn, tsEnable} = 2'b00;
      pulse_clear();
   endtask : t_ts
   task automatic t_tamp;
      bk_write(5'h1F, 32'hA5C30F96);
      tick(2);
      chk(bkRdData_q, 32'hA5C30F96);
      tampFiltEn = 3'b011;
      tampIn[0] = 1;
      tick(FL - 1);
      tampIn[0] = 0;
      tick(3);
      chk({flags_q[6:4], bkRdData_q}, {3'b000, 32'hA5C30F96});
      tampIn[1] = 1;
      tick(FL + 2);
      chk({flags_q[5:4], bkRdData_q}, {2'b10, 32'h0});
      pulse_clear();
      bk_write(5'h05, 32'h12345678);
      tick(2);
      chk(bkRdData_q, 32'h12345678);
      tampIn[2] = 1;
      tick(2);
      chk({flags_q[6], bkRdData_q}, {1'b1, 32'h0});
      pulse_clear();
   endtask : t_tamp
   task automatic t_alarm;
      set_time(8'h00, 8'h00, 8'h00, 24'h010101, 0, 0);
      {alarmSec[0], alarmMask, alarmEnable, irqEnable, sleepReq} = {8'h01, 8'hFE, 2'b11, 7'h01, 1'b1};
      tick(1);
      sleepReq = 0;
      shift_sec(1, '0);
      chk({pwrState, sec_q, flags_q[1:0]}, {PWR_STANDBY, 8'h01, 2'b11});
      tick(2);
      chk({irq_q, wakeReq_q}, 2'b11);
      tick(20);
      chk({pwrState, wakeReq_q, exitLate_q}, {PWR_RUN, 2'b00});
      irqEnable = '0;
      tick(2);
      chk({irq_q, flags_q[0]}, 2'b01);
      alarmEnable = '0;
      pulse_clear();
      tick(2);
      chk(flags_q[3:0], 4'h0);
   endtask : t_alarm
   task automatic t_wake;
      int n = 0;
      {exitDelay, irqEnable, sleepReq, wakeEnable} = {16'h0514, 7'h04, 2'b11};
      tick(1);
      sleepReq = 0;
      while (flags_q[FLG_WAKE] !== 1'b1 && n < 3000) begin
         tick(1);
         n++;
      end
      chk(n > 2395 && n < 2405, 1'b1);
      tick(1250);
      chk(exitLate_q, 1'b1);
      {wakeEnable, irqEnable} = '0;
      pulse_clear();
   endtask : t_wake
   task automatic t_cal;
      time t0;
      @(calOut_q) t0 = $time;
      @(calOut_q) chk(($time - t0) / CLK_NS, PR);
      tick(1);
   endtask : t_cal
   task automatic finish_test;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   initial begin
      #(50 * 20000);
      n_errors++;
      finish_test();
   end
   initial begin
      tick(2);
      rst_n = 1;
      tick(2);
      chk({year_q, mon_q, date_q, hour_q, min_q, sec_q, flags_q, irq_q}, 56'h00010100000000);
      chk({xtalOn_q, intOscOn_q}, 2'b10);
      t_cal();
      t_roll();
      t_ts();
      t_tamp();
      t_alarm();
      t_wake();
      finish_test();
   end
endmodule : lpcb_rtc_bench
